// ### rtl/mcc_top.sv
// Purpose: Start, sequence and end read, write and transfer cycles
// Assumes: Requester pins are synchronised; AHB-Lite status access
// Notes:   Operation
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`include "mcc_cfg.svh"

module mcc_top #(
   parameter int CNT_W = 4
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_initiate_memory_req,
   input  wire logic        i_memory_select_in,
   input  wire logic        i_transfer_initiate_req,
   input  wire logic        i_read_write_dir,
   input  wire logic        i_data_sel_bit0,
   input  wire logic        i_data_sel_bit1,
   input  wire logic        i_protect_enable_in,
   input  wire logic [3:0]  i_protect_addr,
   input  wire logic        i_outer_half_enable,
   input  wire logic        i_inner_half_enable,
   input  wire logic        i_protect_error_clear,
   input  wire logic        i_cabinet_clear,
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   output logic             o_cycle_start_pulse,
   output logic             o_memory_initiate_out,
   output logic             o_transfer_cycle_flag,
   output logic             o_xfer_gate_enable,
   output logic             o_read_gate_enable,
   output logic             o_buffer_data_strobe,
   output logic             o_buffer_out_select_a,
   output logic             o_buffer_out_select_b,
   output logic             o_io_out_select_a,
   output logic             o_io_out_select_b,
   output logic             o_buffer_read_select,
   output logic             o_io_read_select,
   output logic             o_io_write_select,
   output logic             o_pe_source_select,
   output logic             o_outer_half_enable_latched,
   output logic             o_inner_half_enable_latched,
   output logic             o_outer_write_enable,
   output logic             o_inner_write_enable,
   output logic             o_protect_error_flag
);
   ////////////////////////////////////////////////////////////////////////
   // Timing instants in cycles after arrival
   localparam logic [CNT_W-1:0] K_PROT  = CNT_W'(`MCC_CYC(`MCC_T_PROT_NS));
   localparam logic [CNT_W-1:0] K_WINIT = CNT_W'(`MCC_CYC(`MCC_T_WINIT_NS));
   localparam logic [CNT_W-1:0] K_RDLAT = CNT_W'(`MCC_CYC(`MCC_T_RDLAT_NS));
   localparam logic [CNT_W-1:0] K_TE_S  = CNT_W'(`MCC_CYC(`MCC_T_TE_SET_NS));
   localparam logic [CNT_W-1:0] K_TS_S  = CNT_W'(`MCC_CYC(`MCC_T_TS_SET_NS));
   localparam logic [CNT_W-1:0] K_TS_R  = CNT_W'(`MCC_CYC(`MCC_T_TS_RST_NS));
   localparam logic [CNT_W-1:0] K_CRST  = CNT_W'(`MCC_CYC(`MCC_T_CTRL_RST_NS));
   localparam logic [CNT_W-1:0] K_TE_R  = CNT_W'(`MCC_CYC(`MCC_T_TE_RST_NS));
   localparam logic [CNT_W-1:0] K_OE_S  = CNT_W'(`MCC_CYC(`MCC_T_OE_SET_NS));
   localparam logic [CNT_W-1:0] K_OS_S  = CNT_W'(`MCC_CYC(`MCC_T_OS_SET_NS));
   localparam logic [CNT_W-1:0] K_OS_R  = CNT_W'(`MCC_CYC(`MCC_T_OS_RST_NS));
   localparam logic [CNT_W-1:0] K_OE_R  = CNT_W'(`MCC_CYC(`MCC_T_OE_RST_NS));

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   localparam int PIN_W = 15;
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_m_q;
   logic [PIN_W-1:0] pin_s_q;

   assign pin_raw = {i_initiate_memory_req, i_memory_select_in,
                     i_transfer_initiate_req, i_read_write_dir,
                     i_data_sel_bit1, i_data_sel_bit0, i_protect_enable_in,
                     i_protect_addr, i_outer_half_enable,
                     i_inner_half_enable, i_protect_error_clear,
                     i_cabinet_clear};

   always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         pin_m_q <= '0;
         pin_s_q <= '0;
      end else begin
         pin_m_q <= pin_raw;
         pin_s_q <= pin_m_q;
      end
   end

   wire logic imc_s   = pin_s_q[14];
   wire logic msel_s  = pin_s_q[13];
   wire logic xfer_s  = pin_s_q[12];
   wire logic eclr_s  = pin_s_q[1];
   wire logic clr     = !i_resetn || pin_s_q[0];

   ////////////////////////////////////////////////////////////////////////
   // Cycle capture and sequencer
   mcc_pkg::mcc_state_t state_q;
   mcc_pkg::mcc_state_t state_d;
   mcc_pkg::mcc_req_t   req_q;
   mcc_pkg::mcc_req_t   req_in;
   logic [CNT_W-1:0]    cnt_q;
   logic                acc_en;
   logic                sw_clr;

   wire logic rw_start  = imc_s && msel_s;
   wire logic start     = acc_en && (rw_start || xfer_s);
   wire logic run       = (state_q == mcc_pkg::MCC_RUN);
   wire logic at_end    = run && (cnt_q == K_OE_R);

   assign req_in.xfer     = xfer_s;
   assign req_in.write    = pin_s_q[11] && !xfer_s;
   assign req_in.sel      = mcc_pkg::mcc_sel_t'(pin_s_q[10:9]);
   assign req_in.prot_en  = pin_s_q[8];
   assign req_in.addr     = pin_s_q[7:4];
   assign req_in.en_outer = pin_s_q[3];
   assign req_in.en_inner = pin_s_q[2];

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         mcc_pkg::MCC_IDLE: begin
            if (start) begin
               state_d = mcc_pkg::MCC_RUN;
            end
         end
         mcc_pkg::MCC_RUN: begin
            if (at_end && !start) begin
               state_d = mcc_pkg::MCC_IDLE;
            end
         end
         default: state_d = mcc_pkg::MCC_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (clr) begin
         state_q <= mcc_pkg::MCC_IDLE;
         req_q   <= '0;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         if (start) begin
            req_q <= req_in;
            cnt_q <= CNT_W'(1);
         end else if (run) begin
            cnt_q <= cnt_q + CNT_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Timed events and data select decode
   wire logic ev_prot   = run && cnt_q == K_PROT && !req_q.xfer;
   wire logic ev_winit  = run && cnt_q == K_WINIT;
   wire logic ev_rdlat  = run && cnt_q == K_RDLAT;
   wire logic ev_crst   = run && cnt_q == K_CRST;
   wire logic is_read   = !req_q.write && !req_q.xfer;
   wire logic is_write  = req_q.write;
   wire logic dst_cu    = is_read && req_q.sel == mcc_pkg::MCC_SEL_CU;
   wire logic dst_io    = is_read && req_q.sel == mcc_pkg::MCC_SEL_IO;
   wire logic src_io    = is_write && req_q.sel == mcc_pkg::MCC_SEL_IO;
   wire logic src_pe    = (is_write && req_q.sel == mcc_pkg::MCC_SEL_PE)
                          || req_q.xfer;
   wire logic full_word = is_write && (req_q.sel == mcc_pkg::MCC_SEL_CU
                          || req_q.sel == mcc_pkg::MCC_SEL_IO);
   wire logic violation = is_write && req_q.prot_en
                          && req_q.addr == `MCC_PROT_BLOCK;
   wire logic outer_en  = full_word || req_q.en_outer;
   wire logic inner_en  = full_word || req_q.en_inner;

   ////////////////////////////////////////////////////////////////////////
   // Control flip-flops
   logic we_q;
   logic xf_q;
   logic te_q;
   logic oe_q;
   logic st_q;
   logic bl_q;
   logic il_q;
   logic err_q;

   wire logic we_d  = ev_crst ? 1'b0
                    : (ev_prot && is_write && !violation) ? 1'b1
                    : we_q;
   wire logic xf_d  = start ? xfer_s : ev_crst ? 1'b0 : xf_q;
   wire logic te_d  = (run && req_q.xfer && cnt_q == K_TE_S) ? 1'b1
                    : (run && cnt_q == K_TE_R) ? 1'b0 : te_q;
   wire logic oe_d  = (run && is_read && cnt_q == K_OE_S) ? 1'b1
                    : (run && cnt_q == K_OE_R) ? 1'b0 : oe_q;
   wire logic rs_s  = run && is_read && cnt_q == K_OS_S;
   wire logic ts_s  = run && req_q.xfer && cnt_q == K_TS_S;
   wire logic st_r  = run && ((req_q.xfer && cnt_q == K_TS_R)
                      || (is_read && cnt_q == K_OS_R));
   wire logic st_d  = (rs_s || ts_s) ? 1'b1 : st_r ? 1'b0 : st_q;
   wire logic bl_d  = (ev_rdlat && dst_cu) ? 1'b1
                    : at_end ? 1'b0 : bl_q;
   wire logic il_d  = (ev_rdlat && dst_io) ? 1'b1
                    : at_end ? 1'b0 : il_q;
   wire logic eset  = ev_prot && violation;
   wire logic err_d = eset ? 1'b1 : (eclr_s || sw_clr) ? 1'b0
                    : err_q;
   wire logic bsel  = te_d || (oe_d && bl_d);
   wire logic isel  = oe_d && il_d;
   wire logic minit = (start && rw_start && !req_in.write)
                      || (ev_winit && is_write && !violation);

   always_ff @(posedge i_ref_clk) begin
      if (clr) begin
         we_q <= 1'b0;
         xf_q <= 1'b0;
         te_q <= 1'b0;
         oe_q <= 1'b0;
         st_q <= 1'b0;
         bl_q <= 1'b0;
         il_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         we_q <= we_d;
         xf_q <= xf_d;
         te_q <= te_d;
         oe_q <= oe_d;
         st_q <= st_d;
         bl_q <= bl_d;
         il_q <= il_d;
         err_q <= err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge i_ref_clk) begin
      if (clr) begin
         o_cycle_start_pulse         <= 1'b0;
         o_memory_initiate_out       <= 1'b0;
         o_buffer_out_select_a       <= 1'b0;
         o_buffer_out_select_b       <= 1'b0;
         o_io_out_select_a           <= 1'b0;
         o_io_out_select_b           <= 1'b0;
         o_buffer_read_select        <= 1'b0;
         o_io_read_select            <= 1'b0;
         o_io_write_select           <= 1'b0;
         o_pe_source_select          <= 1'b0;
         o_outer_half_enable_latched <= 1'b0;
         o_inner_half_enable_latched <= 1'b0;
         o_outer_write_enable        <= 1'b0;
         o_inner_write_enable        <= 1'b0;
      end else begin
         o_cycle_start_pulse         <= start;
         o_memory_initiate_out       <= minit;
         o_buffer_out_select_a       <= bsel;
         o_buffer_out_select_b       <= bsel;
         o_io_out_select_a           <= isel;
         o_io_out_select_b           <= isel;
         o_buffer_read_select        <= run && dst_cu;
         o_io_read_select            <= run && dst_io;
         o_io_write_select           <= run && src_io;
         o_pe_source_select          <= run && src_pe;
         o_outer_half_enable_latched <= run && outer_en;
         o_inner_half_enable_latched <= run && inner_en;
         o_outer_write_enable        <= we_d && outer_en;
         o_inner_write_enable        <= we_d && inner_en;
      end
   end

   assign o_transfer_cycle_flag = xf_q;
   assign o_xfer_gate_enable    = te_q;
   assign o_read_gate_enable    = oe_q;
   assign o_buffer_data_strobe  = st_q;
   assign o_protect_error_flag  = err_q;

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: control and status
   logic        ap_wr_q;
   logic        ap_ctl_q;
   logic [31:0] ctrl_q;

   wire logic  ap_valid = i_hsel && i_htrans[1] && i_hready;
   wire logic  hit_ctl  = i_haddr[7:0] == `MCC_OFS_CTRL;
   wire logic  hit_st   = i_haddr[7:0] == `MCC_OFS_STATUS;
   wire logic  ctl_wr   = ap_wr_q && ap_ctl_q;
   wire logic [31:0] st_word = {26'h0, req_q.sel, 1'b0, xf_q, run, err_q};
   wire logic [31:0] rd_mux  = hit_ctl ? ctrl_q : hit_st ? st_word
                                       : 32'h0000_0000;

   assign acc_en = ctrl_q[`MCC_CTRL_ACC_BIT];
   assign sw_clr = ctl_wr && i_hwdata[`MCC_CTRL_CLR_BIT];

   always_ff @(posedge i_ref_clk) begin
      if (clr) begin
         ap_wr_q     <= 1'b0;
         ap_ctl_q    <= 1'b0;
         ctrl_q      <= `MCC_CTRL_RST;
         o_hrdata    <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end else begin
         ap_wr_q  <= ap_valid && i_hwrite;
         ap_ctl_q <= hit_ctl;
         if (ctl_wr) begin
            ctrl_q <= {31'h0000_0000, i_hwdata[`MCC_CTRL_ACC_BIT]};
         end
         if (ap_valid && !i_hwrite) begin
            o_hrdata <= rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (clr);

   chk_start_pulse: assert property (
      start |=> o_cycle_start_pulse ##1 !o_cycle_start_pulse || start)
      else $error("cycle start pulse missing or wide");
   chk_prot_deny: assert property (
      ev_prot && violation |=> !we_q ##1 !o_outer_write_enable[*2])
      else $error("write enabled in protected block");
   chk_err_set: assert property (
      eset |=> o_protect_error_flag)
      else $error("protect error not latched");
   chk_err_clear: assert property (
      eclr_s && !eset |=> !o_protect_error_flag)
      else $error("protect error not cleared");
   chk_err_hold: assert property (
      err_q && !eclr_s && !sw_clr |=> err_q)
      else $error("protect error lost");
   chk_full_word: assert property (
      o_io_write_select |-> o_outer_half_enable_latched
                            && o_inner_half_enable_latched)
      else $error("IO write not full word");
   chk_oe_window: assert property (
      $rose(o_read_gate_enable) |-> o_read_gate_enable[*2]
                                    ##1 !o_read_gate_enable)
      else $error("output enable window length wrong");
   chk_xfer_no_we: assert property (
      o_transfer_cycle_flag |-> !we_q)
      else $error("write enable during transfer");
   chk_io_gate: assert property (
      o_io_out_select_a |-> o_read_gate_enable && il_q)
      else $error("IO select outside window");
   chk_ctrl_reset: assert property (
      ev_crst && !start |=> !we_q && !xf_q)
      else $error("control reset ineffective");
   chk_te_window: assert property (
      $rose(te_q) |-> te_q[*3] ##1 !te_q)
      else $error("transfer window length wrong");

   cov_read_io: cover property ($rose(o_io_out_select_a));
   cov_write: cover property (o_outer_write_enable);
   cov_xfer: cover property ($rose(o_buffer_out_select_a) && te_q);
   cov_err: cover property (eset);

endmodule : mcc_top

// ### rtl/mcc_cfg.svh
// Purpose: Constants of the memory cycle control block
// Assumes: 25 MHz reference clock
// Notes:   Times in ns, cycle counts derived from them
`ifndef MCC_CFG_SVH
`define MCC_CFG_SVH
`define MCC_CLK_NS        40
`define MCC_CYC(ns)       (((ns) + `MCC_CLK_NS / 2) / `MCC_CLK_NS)
`define MCC_T_PROT_NS     40
`define MCC_T_WINIT_NS    55
`define MCC_T_RDLAT_NS    130
`define MCC_T_TE_SET_NS   165
`define MCC_T_TS_SET_NS   185
`define MCC_T_TS_RST_NS   245
`define MCC_T_CTRL_RST_NS 250
`define MCC_T_TE_RST_NS   265
`define MCC_T_OE_SET_NS   270
`define MCC_T_OS_SET_NS   290
`define MCC_T_OS_RST_NS   350
`define MCC_T_OE_RST_NS   370
`define MCC_T_PULSE_NS    50
`define MCC_PROT_BLOCK    4'h0
`define MCC_OFS_CTRL      8'h00
`define MCC_OFS_STATUS    8'h04
`define MCC_CTRL_RST      32'h0000_0001
`define MCC_CTRL_ACC_BIT  0
`define MCC_CTRL_CLR_BIT  1
`define MCC_ST_ERR_BIT    0
`define MCC_ST_BUSY_BIT   1
`define MCC_ST_XFER_BIT   2
`define MCC_ST_SEL_LSB    4
`endif

// ### rtl/mcc_pkg.sv
// Purpose: Types of the memory cycle control block
// Assumes: Nothing
// Notes:   Data select codes name source or destination
package mcc_pkg;
   typedef enum logic [1:0] {
      MCC_SEL_PE = 2'h0,
      MCC_SEL_CU = 2'h1,
      MCC_SEL_IO = 2'h2,
      MCC_SEL_RS = 2'h3
   } mcc_sel_t;

   typedef enum logic [1:0] {
      MCC_IDLE = 2'h1,
      MCC_RUN  = 2'h2
   } mcc_state_t;

   typedef struct packed {
      logic     xfer;
      logic     write;
      mcc_sel_t sel;
      logic     prot_en;
      logic [3:0] addr;
      logic     en_outer;
      logic     en_inner;
   } mcc_req_t;
endpackage : mcc_pkg

// ### sim/mcc_pe_model.sv
// Purpose: Requester model relaying control unit cycle requests
// Assumes: Pins change by non-blocking assignment after a rising edge
// Notes:   Qualifier levels are held until the next initiate pulse
`timescale 1ns/10ps

module mcc_pe_model (
   input  wire logic  i_ref_clk,
   output logic       o_init,
   output logic       o_msel,
   output logic       o_xfer,
   output logic       o_dir,
   output logic       o_sel0,
   output logic       o_sel1,
   output logic       o_pen,
   output logic [3:0] o_addr,
   output logic       o_outer,
   output logic       o_inner,
   output logic       o_clr
);
   initial begin
      {o_init, o_msel, o_xfer, o_dir, o_sel0, o_sel1} = 6'h0;
      {o_pen, o_addr, o_outer, o_inner, o_clr} = 8'h0;
   end

   ////////////////////////////////////////////////////////////////////
   // One-clock initiate pulse, qualifiers set alongside and held
   task automatic start(input logic xf, input logic msel, input logic wr,
                        input logic [1:0] sel, input logic pen,
                        input logic [3:0] adr, input logic [1:0] hv);
      @(posedge i_ref_clk);
      o_msel <= msel;
      o_dir <= wr;
      {o_sel1, o_sel0} <= sel;
      o_pen <= pen;
      o_addr <= adr;
      {o_outer, o_inner} <= hv;
      o_init <= !xf;
      o_xfer <= xf;
      @(posedge i_ref_clk);
      o_init <= 1'b0;
      o_xfer <= 1'b0;
   endtask : start

   // One-clock error reset pulse
   task automatic clear_err();
      @(posedge i_ref_clk);
      o_clr <= 1'b1;
      @(posedge i_ref_clk);
      o_clr <= 1'b0;
   endtask : clear_err
endmodule : mcc_pe_model

// ### sim/tb.sv
// Purpose: Self-checking bench of the memory cycle control block
// Assumes: One AHB-Lite master, one requester model
// Notes:   Windows sampled at offsets from the cycle start pulse
`timescale 1ns/10ps

module tb;
   typedef struct packed {
      logic [1:0] kind;
      logic [1:0] sel;
      logic [1:0] hv;
      logic       viol;
      logic       err;
   } mcc_tb_note_t;

   logic        i_ref_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic        i_cabinet_clear = 1'b0;
   logic        i_hsel = 1'b0;
   logic        i_hwrite = 1'b0;
   logic [31:0] i_haddr = 32'h0;
   logic [31:0] i_hwdata = 32'h0;
   logic [1:0]  i_htrans = 2'h0;
   logic [2:0]  i_hsize = 3'h2;
   wire logic i_initiate_memory_req, i_memory_select_in, i_read_write_dir;
   wire logic i_transfer_initiate_req, i_data_sel_bit0, i_data_sel_bit1;
   wire logic i_protect_enable_in, i_outer_half_enable, i_inner_half_enable;
   wire logic i_protect_error_clear;
   wire logic [3:0] i_protect_addr;
   logic o_hreadyout, o_hresp, o_cycle_start_pulse, o_memory_initiate_out;
   logic o_transfer_cycle_flag, o_xfer_gate_enable, o_read_gate_enable;
   logic o_buffer_data_strobe, o_buffer_out_select_a, o_buffer_out_select_b;
   logic o_io_out_select_a, o_io_out_select_b, o_buffer_read_select;
   logic o_io_read_select, o_io_write_select, o_pe_source_select;
   logic o_outer_half_enable_latched, o_inner_half_enable_latched;
   logic o_outer_write_enable, o_inner_write_enable, o_protect_error_flag;
   logic [31:0] o_hrdata;
   wire logic i_hready = o_hreadyout;
   wire logic [17:0] probe = {o_outer_half_enable_latched,
      o_inner_half_enable_latched, o_cycle_start_pulse, o_read_gate_enable,
      o_xfer_gate_enable, o_buffer_data_strobe, o_buffer_out_select_a,
      o_buffer_out_select_b, o_io_out_select_a, o_io_out_select_b,
      o_memory_initiate_out, o_io_write_select, o_pe_source_select,
      o_buffer_read_select, o_io_read_select, o_outer_write_enable,
      o_inner_write_enable, o_transfer_cycle_flag};
   int           miscompares = 0;
   int           n_compared = 0;
   mcc_tb_note_t notes[$];
   logic         err_q = 1'b0;
   logic [31:0]  rng = 32'h0000_995A;

   mcc_top dut (.i_ref_clk, .i_resetn, .i_initiate_memory_req,
      .i_memory_select_in, .i_transfer_initiate_req, .i_read_write_dir,
      .i_data_sel_bit0, .i_data_sel_bit1, .i_protect_enable_in,
      .i_protect_addr, .i_outer_half_enable, .i_inner_half_enable,
      .i_protect_error_clear, .i_cabinet_clear, .i_hsel, .i_haddr,
      .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hreadyout,
      .o_hresp, .o_hrdata, .o_cycle_start_pulse, .o_memory_initiate_out,
      .o_transfer_cycle_flag, .o_xfer_gate_enable, .o_read_gate_enable,
      .o_buffer_data_strobe, .o_buffer_out_select_a, .o_buffer_out_select_b,
      .o_io_out_select_a, .o_io_out_select_b, .o_buffer_read_select,
      .o_io_read_select, .o_io_write_select, .o_pe_source_select,
      .o_outer_half_enable_latched, .o_inner_half_enable_latched,
      .o_outer_write_enable, .o_inner_write_enable, .o_protect_error_flag);

   mcc_pe_model u_pe (.i_ref_clk, .o_init(i_initiate_memory_req),
      .o_msel(i_memory_select_in), .o_xfer(i_transfer_initiate_req),
      .o_dir(i_read_write_dir), .o_sel0(i_data_sel_bit0),
      .o_sel1(i_data_sel_bit1), .o_pen(i_protect_enable_in),
      .o_addr(i_protect_addr), .o_outer(i_outer_half_enable),
      .o_inner(i_inner_half_enable), .o_clr(i_protect_error_clear));

   always #20 i_ref_clk = ~i_ref_clk;

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nxt();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : nxt

   task automatic cmp(input string nm, input logic [11:0] e, g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : cmp

   task automatic cmp_word(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : cmp_word

   task automatic report_and_stop();
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // Single AHB-Lite transfer; read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [31:0] a, d,
                      output logic [31:0] r);
      @(posedge i_ref_clk);
      i_hsel <= 1'b1;
      i_haddr <= a;
      i_htrans <= 2'h2;
      i_hwrite <= wr;
      i_hsize <= 3'h2;
      @(posedge i_ref_clk);
      while (i_hready !== 1'b1) begin
         @(posedge i_ref_clk);
      end
      i_hsel <= 1'b0;
      i_htrans <= 2'h0;
      i_hwdata <= d;
      @(posedge i_ref_clk);
      while (i_hready !== 1'b1) begin
         @(posedge i_ref_clk);
      end
      r = o_hrdata;
   endtask : ahb

   task automatic ahb_chk(input logic [31:0] a, e);
      logic [31:0] r;
      ahb(1'b0, a, 32'h0, r);
      cmp_word("hrdata", e, r);
      cmp("hresp", 12'h0, {11'h0, o_hresp});
   endtask : ahb_chk

   task automatic chk_err();
      cmp("prot_err", {11'h0, err_q}, {11'h0, o_protect_error_flag});
   endtask : chk_err

   // Note the expected cycle, then have the requester start it
   task automatic go(input logic [1:0] kind, sel, input logic pen,
                     input logic [3:0] adr, input logic [1:0] hv);
      mcc_tb_note_t n;
      n.kind = kind;
      n.sel = sel;
      n.hv = hv;
      n.viol = (kind == 2'h1) && pen && (adr == 4'h0);
      if (n.viol)
         err_q = 1'b1;
      n.err = err_q;
      notes.push_back(n);
      u_pe.start(kind == 2'h2, 1'b1, kind == 2'h1, sel, pen, adr, hv);
      repeat (16) @(posedge i_ref_clk);
   endtask : go

   ////////////////////////////////////////////////////////////////////
   always begin : watch
      mcc_tb_note_t n;
      logic [11:0] w [18];
      logic [11:0] bx;
      logic rd, wr, xf, pe, ok;
      @(posedge i_ref_clk);
      #1;
      if (o_cycle_start_pulse === 1'b1) begin
         if (notes.size() == 0)
            cmp("cycle_start", 12'h0, 12'h1);
         else begin
            n = notes.pop_front();
            for (int i = 0; i < 12; i++) begin
               for (int j = 0; j < 18; j++)
                  w[j][i] = probe[j];
               if (i < 11) begin
                  @(posedge i_ref_clk);
                  #1;
               end
            end
            rd = n.kind == 2'h0;
            wr = n.kind == 2'h1;
            xf = n.kind == 2'h2;
            pe = n.sel == mcc_pkg::MCC_SEL_PE;
            ok = wr && !n.viol;
            bx = (rd && n.sel == mcc_pkg::MCC_SEL_CU) ? 12'h180 :
                 (xf ? 12'h070 : 12'h000);
            cmp("cycle_start", 12'h001, w[15]);
            if (rd) cmp("read_gate", 12'h180, w[14]);
            if (xf) cmp("xfer_gate", 12'h070, w[13]);
            if (!wr) cmp("strobe", rd ? 12'h180 : 12'h020, w[12]);
            if (!wr) cmp("buf_sel_a", bx, w[11]);
            if (!wr) cmp("buf_sel_b", bx, w[10]);
            bx = (rd && n.sel == mcc_pkg::MCC_SEL_IO) ? 12'h180 : 12'h000;
            if (!wr) cmp("io_sel_a", bx, w[9]);
            if (!wr) cmp("io_sel_b", bx, w[8]);
            bx = rd ? 12'h001 : (ok ? 12'h002 : 12'h000);
            if (!xf) cmp("mem_init", bx, w[7]);
            bx = {11'h0, wr && n.sel == mcc_pkg::MCC_SEL_IO};
            if (!n.viol) cmp("io_wr_sel", bx, {11'h0, |w[6]});
            bx = {11'h0, (wr || xf) && pe};
            if (!n.viol) cmp("pe_src_sel", bx, {11'h0, |w[5]});
            bx = {11'h0, rd && n.sel == mcc_pkg::MCC_SEL_CU};
            cmp("buf_rd_sel", bx, {11'h0, |w[4]});
            bx = {11'h0, rd && n.sel == mcc_pkg::MCC_SEL_IO};
            cmp("io_rd_sel", bx, {11'h0, |w[3]});
            bx = (ok && (!pe || n.hv[1])) ? 12'h03E : 12'h000;
            cmp("outer_we", bx, w[2]);
            bx = (ok && (!pe || n.hv[0])) ? 12'h03E : 12'h000;
            cmp("inner_we", bx, w[1]);
            cmp("xfer_flag", {11'h0, xf}, {11'h0, |w[0]});
            bx = {11'h0, (wr && !pe) || n.hv[1]};
            cmp("outer_lat", bx, {11'h0, |w[17]});
            bx = {11'h0, (wr && !pe) || n.hv[0]};
            cmp("inner_lat", bx, {11'h0, |w[16]});
            cmp("prot_err", {11'h0, n.err}, {11'h0, o_protect_error_flag});
         end
      end
   end

   initial begin : wdog
      repeat (4000) @(posedge i_ref_clk);
      miscompares++;
      report_and_stop();
   end

   initial begin : main
      logic [31:0] r;
      repeat (16) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      ahb_chk(32'h0, 32'h1);
      ahb_chk(32'h4, 32'h0);
      ahb(1'b1, 32'h10, 32'hFFFF_FFFF, r);
      ahb_chk(32'h10, 32'h0);
      for (int s = 0; s < 3; s++)
         go(2'h0, 2'(s), 1'b1, 4'h0, 2'h0);
      go(2'h2, 2'h0, 1'b1, 4'h0, 2'h2);
      go(2'h2, 2'h0, 1'b0, 4'h5, 2'h1);
      for (int s = 0; s < 3; s++)
         go(2'h1, 2'(s), 1'b0, 4'h0, 2'h0);
      for (int i = 0; i < 8; i++) begin
         r = nxt();
         go({1'b0, r[0]}, (r[2:1] == 2'h3) ? 2'h0 : r[2:1], r[3], r[7:4],
            r[9:8]);
      end
      go(2'h1, 2'h0, 1'b1, 4'h0, 2'h3);
      go(2'h1, 2'h0, 1'b1, 4'h1, 2'h1);
      ahb_chk(32'h4, 32'h1);
      u_pe.clear_err();
      err_q = 1'b0;
      repeat (6) @(posedge i_ref_clk);
      chk_err();
      go(2'h1, 2'h1, 1'b1, 4'h0, 2'h0);
      ahb(1'b1, 32'h0, 32'h3, r);
      err_q = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      chk_err();
      u_pe.start(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 4'h3, 2'h0);
      repeat (16) @(posedge i_ref_clk);
      ahb(1'b1, 32'h0, 32'h0, r);
      u_pe.start(1'b0, 1'b1, 1'b0, 2'h1, 1'b0, 4'h3, 2'h0);
      repeat (16) @(posedge i_ref_clk);
      ahb(1'b1, 32'h0, 32'h1, r);
      go(2'h1, 2'h0, 1'b1, 4'h0, 2'h3);
      i_cabinet_clear <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      i_cabinet_clear <= 1'b0;
      err_q = 1'b0;
      repeat (4) @(posedge i_ref_clk);
      chk_err();
      ahb_chk(32'h0, 32'h1);
      go(2'h0, 2'h2, 1'b0, 4'h2, 2'h0);
      cmp("notes_left", 12'h0, 12'(notes.size()));
      report_and_stop();
   end
endmodule : tb
